//--- verilog/mcu_timing_reset_single_step.sv
`timescale 1ns/1ns
module mcu_timing_reset_single_step #(
   parameter int unsigned POR_HOLD_CYCLES = mcu_timing_pkg::POR_HOLD_CYC
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // processor control pins
   input  wire logic        cpu_reset_n,
   input  wire logic        external_fetch_select,
   input  wire logic        step_req_n,
   input  wire logic [7:0]  opcode_in,
   input  wire logic        timer_ovf_evt,
   // strobes
   output logic             ale,
   output logic             program_store_strobe_n,
   // first test pin, two-way
   output logic             first_test_pin_o,
   output logic             first_test_pin_oe_n,
   // bus port, two-way
   output logic      [7:0]  bus_o,
   output logic             bus_oe_n,
   // ports 1 and 2
   output logic      [7:0]  port1_o,
   output logic             port1_oe_n,
   output logic      [7:0]  port2_o,
   output logic      [7:0]  port2_oe_n
);

   generate
      if (POR_HOLD_CYCLES < 1 || POR_HOLD_CYCLES > 4194303) begin : g_bad
         $error("mcu_timing_reset_single_step: bad reset hold count");
      end
   endgenerate

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // two-cycle opcodes: upper nibble pattern x1x1
   function automatic logic two_cycle(input logic [7:0] op);
      two_cycle = op[4] & op[6];
   endfunction

   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   step_if t ();

   logic        cpu_rst;
   logic        wr_en;
   logic        rd_en;
   logic        fetch_s4;
   logic [11:0] pc_r;
   logic [2:0]  sp_r;
   logic [7:0]  opcode_r;
   logic        first_r;
   logic        uf0_r;
   logic        uf1_r;
   logic        rbank_r;
   logic        mbank_r;
   logic        tie_r;
   logic        xie_r;
   logic        trun_r;
   logic        tflag_r;
   logic        clkout_r;
   logic [7:0]  busbuf_r;
   logic        busdrv_r;
   logic [7:0]  p1_r;
   logic [7:0]  p2_r;
   logic        p1drv_r;
   logic        p2drv_r;
   logic [21:0] por_cnt_r;
   logic        por_ok_r;
   logic [31:0] rd_nxt;

   assign cpu_rst  = !cpu_reset_n;
   assign wr_en    = psel && penable && pready && pwrite;
   assign rd_en    = psel && !penable && !pwrite;
   assign fetch_s4 = t.fetch_next && t.state_idx >= mcu_timing_pkg::ST_S4;

   // ------------------------------------------------------------
   // timing and single step
   // ------------------------------------------------------------
   state_timing #(
      .DIV     (mcu_timing_pkg::STATE_DIV),
      .NSTATES (mcu_timing_pkg::CYCLE_STATES)
   ) u_timing (
      .pclk    (pclk),
      .presetn (presetn),
      .t       (t.gen)
   );

   step_control u_step (
      .pclk       (pclk),
      .presetn    (presetn),
      .step_req_n (step_req_n),
      .t          (t.step)
   );

   // ------------------------------------------------------------
   // instruction sequencing
   // ------------------------------------------------------------
   // next cycle opens an instruction unless a two-cycle op is half done
   assign t.fetch_next = !(first_r && two_cycle(opcode_r));

   // cycle position and opcode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_r  <= 1'b1;
         opcode_r <= 8'h00;
      end else if (cpu_rst) begin
         first_r  <= 1'b1;
         opcode_r <= 8'h00;
      end else if (t.state_en && !t.halt) begin
         if (first_r && t.state_idx == mcu_timing_pkg::ST_S1) begin
            opcode_r <= opcode_in;
         end
         if (t.state_idx == mcu_timing_pkg::ST_S5) begin
            first_r <= t.fetch_next;
         end
      end
   end

   // program counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_r <= mcu_timing_pkg::PC_RST;
      end else if (cpu_rst) begin
         pc_r <= mcu_timing_pkg::PC_RST;
      end else if (t.state_en && !t.halt) begin
         if (first_r && t.state_idx == mcu_timing_pkg::ST_S2) begin
            pc_r <= pc_r + 12'h001;
         end else if (!first_r && t.state_idx == mcu_timing_pkg::ST_S3) begin
            pc_r <= pc_r + 12'h001; // immediate byte of second cycle
         end
      end
   end

   // ------------------------------------------------------------
   // strobes
   // ------------------------------------------------------------
   // strobe high through S5 and through a halt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ale <= 1'b0;
      end else begin
         ale <= t.halt || t.state_idx == mcu_timing_pkg::ST_S5;
      end
   end

   // program store strobe low in S1 of every machine cycle when fetching outside
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_store_strobe_n <= 1'b1;
      end else begin
         program_store_strobe_n <= !(external_fetch_select && !t.halt
            && t.state_idx == mcu_timing_pkg::ST_S1);
      end
   end

   // ------------------------------------------------------------
   // first test pin clock output
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clkout_r <= 1'b0;
      end else if (cpu_rst) begin
         clkout_r <= 1'b0;
      end else if (wr_en && hit(paddr, mcu_timing_pkg::CTRL_OFS)
                   && pwdata[mcu_timing_pkg::CTRL_CLKCMD]) begin
         clkout_r <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_test_pin_o    <= 1'b0;
         first_test_pin_oe_n <= 1'b1;
      end else begin
         first_test_pin_o    <= clkout_r && t.state_clk;
         first_test_pin_oe_n <= !clkout_r;
      end
   end

   // ------------------------------------------------------------
   // control state: flags, banks, interrupts, timer, stack
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uf0_r   <= 1'b0;
         uf1_r   <= 1'b0;
         rbank_r <= 1'b0;
         mbank_r <= 1'b0;
         tie_r   <= 1'b0;
         xie_r   <= 1'b0;
         trun_r  <= 1'b0;
         sp_r    <= mcu_timing_pkg::SP_RST;
      end else if (cpu_rst) begin
         uf0_r   <= 1'b0;
         uf1_r   <= 1'b0;
         rbank_r <= 1'b0;
         mbank_r <= 1'b0;
         tie_r   <= 1'b0;
         xie_r   <= 1'b0;
         trun_r  <= 1'b0;
         sp_r    <= mcu_timing_pkg::SP_RST;
      end else if (wr_en && hit(paddr, mcu_timing_pkg::CTRL_OFS)) begin
         uf0_r   <= pwdata[mcu_timing_pkg::CTRL_UF0];
         uf1_r   <= pwdata[mcu_timing_pkg::CTRL_UF1];
         rbank_r <= pwdata[mcu_timing_pkg::CTRL_RBANK];
         mbank_r <= pwdata[mcu_timing_pkg::CTRL_MBANK];
         tie_r   <= pwdata[mcu_timing_pkg::CTRL_TIE];
         xie_r   <= pwdata[mcu_timing_pkg::CTRL_XIE];
         trun_r  <= pwdata[mcu_timing_pkg::CTRL_TRUN];
         sp_r    <= pwdata[mcu_timing_pkg::CTRL_SP_LSB +: 3];
      end
   end

   // timer flag: event sets while the timer runs, write one clears, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tflag_r <= 1'b0;
      end else if (cpu_rst) begin
         tflag_r <= 1'b0;
      end else if (timer_ovf_evt && trun_r) begin
         tflag_r <= 1'b1;
      end else if (wr_en && hit(paddr, mcu_timing_pkg::CTRL_OFS)
                   && pwdata[mcu_timing_pkg::CTRL_TFLAG]) begin
         tflag_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // bus output buffer
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busbuf_r <= 8'h00;
         busdrv_r <= 1'b0;
      end else if (cpu_rst) begin
         busdrv_r <= external_fetch_select;
      end else if (t.halt) begin
         busbuf_r <= pc_r[7:0];
      end else if (wr_en && hit(paddr, mcu_timing_pkg::BUSBUF_OFS)) begin
         busbuf_r <= pwdata[7:0];
         busdrv_r <= pwdata[mcu_timing_pkg::BUSBUF_DRV];
      end
   end

   // address through S4 and S5 of a cycle whose next cycle opens an instruction, outside processor reset, and while halted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_o    <= 8'h00;
         bus_oe_n <= 1'b1;
      end else if (t.halt || (!cpu_rst && fetch_s4)) begin
         bus_o    <= pc_r[7:0];
         bus_oe_n <= 1'b0;
      end else begin
         bus_o    <= busbuf_r;
         bus_oe_n <= !busdrv_r;
      end
   end

   // ------------------------------------------------------------
   // ports 1 and 2
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p1_r    <= 8'h00;
         p2_r    <= 8'h00;
         p1drv_r <= 1'b0;
         p2drv_r <= 1'b0;
      end else if (cpu_rst) begin
         p1drv_r <= 1'b0;
         p2drv_r <= 1'b0;
      end else if (wr_en && hit(paddr, mcu_timing_pkg::PORTS_OFS)) begin
         p1_r    <= pwdata[7:0];
         p2_r    <= pwdata[15:8];
         p1drv_r <= pwdata[mcu_timing_pkg::PORTS_P1DRV];
         p2drv_r <= pwdata[mcu_timing_pkg::PORTS_P2DRV];
      end
   end

   // port 2 low nibble carries the upper address while halted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port1_o    <= 8'h00;
         port1_oe_n <= 1'b1;
         port2_o    <= 8'h00;
         port2_oe_n <= 8'hff;
      end else begin
         port1_o    <= p1_r;
         port1_oe_n <= !p1drv_r;
         if (t.halt) begin
            port2_o    <= {p2_r[7:4], pc_r[11:8]};
            port2_oe_n <= {{4{!p2drv_r}}, 4'h0};
         end else begin
            port2_o    <= p2_r;
            port2_oe_n <= {8{!p2drv_r}};
         end
      end
   end

   // ------------------------------------------------------------
   // reset length monitor
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_cnt_r <= 22'h000000;
         por_ok_r  <= 1'b0;
      end else if (cpu_rst) begin
         if (por_cnt_r != 22'(POR_HOLD_CYCLES)) begin
            por_cnt_r <= por_cnt_r + 22'h000001;
         end else begin
            por_ok_r <= 1'b1;
         end
      end else begin
         por_cnt_r <= 22'h000000;
      end
   end

   // ------------------------------------------------------------
   // apb read data and answer
   // ------------------------------------------------------------
   always_comb begin
      rd_nxt = 32'h00000000;
      if (hit(paddr, mcu_timing_pkg::CTRL_OFS)) begin
         rd_nxt[mcu_timing_pkg::CTRL_UF0]          = uf0_r;
         rd_nxt[mcu_timing_pkg::CTRL_UF1]          = uf1_r;
         rd_nxt[mcu_timing_pkg::CTRL_RBANK]        = rbank_r;
         rd_nxt[mcu_timing_pkg::CTRL_MBANK]        = mbank_r;
         rd_nxt[mcu_timing_pkg::CTRL_TIE]          = tie_r;
         rd_nxt[mcu_timing_pkg::CTRL_XIE]          = xie_r;
         rd_nxt[mcu_timing_pkg::CTRL_TRUN]         = trun_r;
         rd_nxt[mcu_timing_pkg::CTRL_TFLAG]        = tflag_r;
         rd_nxt[mcu_timing_pkg::CTRL_CLKOUT]       = clkout_r;
         rd_nxt[mcu_timing_pkg::CTRL_SP_LSB +: 3]  = sp_r;
      end else if (hit(paddr, mcu_timing_pkg::BUSBUF_OFS)) begin
         rd_nxt[7:0]                         = busbuf_r;
         rd_nxt[mcu_timing_pkg::BUSBUF_DRV]  = busdrv_r;
      end else if (hit(paddr, mcu_timing_pkg::PORTS_OFS)) begin
         rd_nxt[7:0]                         = p1_r;
         rd_nxt[15:8]                        = p2_r;
         rd_nxt[mcu_timing_pkg::PORTS_P1DRV] = p1drv_r;
         rd_nxt[mcu_timing_pkg::PORTS_P2DRV] = p2drv_r;
      end else if (hit(paddr, mcu_timing_pkg::STATUS_OFS)) begin
         rd_nxt[11:0]                            = pc_r;
         rd_nxt[mcu_timing_pkg::STAT_ST_LSB +: 3] = t.state_idx;
         rd_nxt[mcu_timing_pkg::STAT_FIRST]      = first_r;
         rd_nxt[mcu_timing_pkg::STAT_HALT]       = t.halt;
         rd_nxt[mcu_timing_pkg::STAT_RST]        = cpu_rst;
         rd_nxt[mcu_timing_pkg::STAT_POROK]      = por_ok_r;
         rd_nxt[mcu_timing_pkg::STAT_OP_LSB +: 8] = opcode_r;
      end
   end

   // no wait state: answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable
                    && !hit(paddr, mcu_timing_pkg::CTRL_OFS)
                    && !hit(paddr, mcu_timing_pkg::BUSBUF_OFS)
                    && !hit(paddr, mcu_timing_pkg::PORTS_OFS)
                    && !hit(paddr, mcu_timing_pkg::STATUS_OFS);
         if (rd_en) begin
            prdata <= rd_nxt;
         end
      end
   end

endmodule // mcu_timing_reset_single_step

//--- verilog/mcu_timing_pkg.sv
package mcu_timing_pkg;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_MHZ      = 250;
   localparam int unsigned STATE_DIV    = 3;
   localparam int unsigned CYCLE_STATES = 5;
   localparam int unsigned POR_HOLD_MS  = 10;
   localparam int unsigned POR_HOLD_CYC = POR_HOLD_MS * CLK_MHZ * 1000;

   // state indices inside a machine cycle
   localparam logic [2:0] ST_S1 = 3'h0;
   localparam logic [2:0] ST_S2 = 3'h1;
   localparam logic [2:0] ST_S3 = 3'h2;
   localparam logic [2:0] ST_S4 = 3'h3;
   localparam logic [2:0] ST_S5 = 3'h4;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] BUSBUF_OFS = 12'h004;
   localparam logic [11:0] PORTS_OFS  = 12'h008;
   localparam logic [11:0] STATUS_OFS = 12'h00c;

   // ctrl fields
   localparam int unsigned CTRL_UF0    = 0;
   localparam int unsigned CTRL_UF1    = 1;
   localparam int unsigned CTRL_RBANK  = 2;
   localparam int unsigned CTRL_MBANK  = 3;
   localparam int unsigned CTRL_TIE    = 4;
   localparam int unsigned CTRL_XIE    = 5;
   localparam int unsigned CTRL_TRUN   = 6;
   localparam int unsigned CTRL_TFLAG  = 7;
   localparam int unsigned CTRL_CLKOUT = 8;
   localparam int unsigned CTRL_SP_LSB = 9;
   localparam int unsigned CTRL_CLKCMD = 31;

   // bus buffer / port fields
   localparam int unsigned BUSBUF_DRV = 8;
   localparam int unsigned PORTS_P1DRV = 16;
   localparam int unsigned PORTS_P2DRV = 17;

   // status fields
   localparam int unsigned STAT_ST_LSB = 12;
   localparam int unsigned STAT_FIRST  = 15;
   localparam int unsigned STAT_HALT   = 16;
   localparam int unsigned STAT_RST    = 17;
   localparam int unsigned STAT_POROK  = 18;
   localparam int unsigned STAT_OP_LSB = 19;

   // reset values
   localparam logic [11:0] PC_RST = 12'h000;
   localparam logic [2:0]  SP_RST = 3'h0;

endpackage

//--- verilog/step_if.sv
`timescale 1ns/1ns
interface step_if;
   logic       state_en;   // one pulse per state time
   logic [2:0] state_idx;  // current state S1..S5
   logic       state_clk;  // divided-by-three level
   logic       fetch_next; // next cycle opens an instruction
   logic       halt;       // single-step stop

   modport gen  (output state_en, state_idx, state_clk, input halt);
   modport step (input state_en, state_idx, fetch_next, output halt);
   modport core (input state_en, state_idx, state_clk, halt,
                 output fetch_next);
endinterface

//--- verilog/state_timing.sv
`timescale 1ns/1ns
module state_timing #(
   parameter int unsigned DIV     = mcu_timing_pkg::STATE_DIV,
   parameter int unsigned NSTATES = mcu_timing_pkg::CYCLE_STATES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // timing carrier
   step_if.gen      t
);

   generate
      if (DIV < 2 || DIV > 15 || NSTATES != 5) begin : g_bad
         $error("state_timing: unsupported divider settings");
      end
   endgenerate

   logic [3:0] div_r;
   logic [2:0] idx_r;

   // ------------------------------------------------------------
   // state counter: oscillator divided by three
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 4'h0;
      end else if (div_r == 4'(DIV - 1)) begin
         div_r <= 4'h0;
      end else begin
         div_r <= div_r + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // cycle counter: five states, frozen in S5 while halted
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_r <= mcu_timing_pkg::ST_S1;
      end else if (t.state_en && !t.halt) begin
         if (idx_r == mcu_timing_pkg::ST_S5) begin
            idx_r <= mcu_timing_pkg::ST_S1;
         end else begin
            idx_r <= idx_r + 3'h1;
         end
      end
   end

   assign t.state_en  = (div_r == 4'(DIV - 1));
   assign t.state_idx = idx_r;
   assign t.state_clk = (div_r == 4'h0);

endmodule // state_timing

//--- verilog/step_control.sv
`timescale 1ns/1ns
module step_control (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // step request pin, active low
   input wire logic step_req_n,
   // timing carrier
   step_if.step     t
);

   logic halt_r;

   // ------------------------------------------------------------
   // stop at the fetch boundary, leave when request rises
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_r <= 1'b0;
      end else if (halt_r) begin
         if (step_req_n) begin
            halt_r <= 1'b0;
         end
      end else if (t.state_en && t.state_idx == mcu_timing_pkg::ST_S4
                   && t.fetch_next && !step_req_n) begin
         halt_r <= 1'b1;
      end
   end

   assign t.halt = halt_r;

endmodule // step_control

//--- sim/mcu_timing_assertions.sv
`timescale 1ns/1ns
module mcu_timing_checker (
   // clock and resets
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       cpu_reset_n,
   // watched pins
   input wire logic       external_fetch_select,
   input wire logic       step_req_n,
   input wire logic       ale,
   input wire logic       program_store_strobe_n,
   input wire logic       first_test_pin_o,
   input wire logic       first_test_pin_oe_n,
   input wire logic [7:0] bus_o,
   input wire logic       bus_oe_n,
   input wire logic [7:0] port2_oe_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // halt shows as the strobe held past its three clocks, request low
   sequence halted_s; ale [*5] ##0 !step_req_n; endsequence
   sequence low_phase_s; (!ale) [*8] ##1 (!ale) [*4]; endsequence
   // ------------------------------------------------------------
   // timing and reset checks
   // ------------------------------------------------------------
   cycle_len_a: assert property ($fell(ale) |-> low_phase_s ##1 ale)
      else $error("strobe low phase is not twelve clocks");
   strobe_high_a: assert property ($rose(ale) |-> ale [*3])
      else $error("strobe high phase too short");
   clk_div_a: assert property (disable iff (!presetn || !cpu_reset_n)
      $rose(first_test_pin_o) |=> (!first_test_pin_o) [*2] ##1 first_test_pin_o)
      else $error("state clock is not one in three");
   clk_off_a: assert property ((!cpu_reset_n) [*3] |-> first_test_pin_oe_n)
      else $error("test pin driven during reset");
   bus_float_a: assert property ((!cpu_reset_n) [*3] |->
      bus_oe_n != external_fetch_select && port2_oe_n == 8'hff)
      else $error("bus or port drive wrong in reset");
   store_sel_a: assert property (!program_store_strobe_n |->
      external_fetch_select || $past(external_fetch_select))
      else $error("store strobe without fetch select");
   store_s1_a: assert property ($fell(ale) && external_fetch_select |->
      ##[0:2] !program_store_strobe_n)
      else $error("no store strobe in first state");
   halt_addr_a: assert property (halted_s |->
      !bus_oe_n && port2_oe_n[3:0] == 4'h0)
      else $error("halt address not driven");
   addr_valid_a: assert property ($rose(ale) |-> $stable(bus_o))
      else $error("bus changed at strobe rise");
   release_a: assert property (halted_s ##1 $rose(step_req_n) |-> ##[1:6] !ale)
      else $error("strobe did not fall on release");
endmodule // mcu_timing_checker

bind mcu_timing_reset_single_step mcu_timing_checker u_chk (
   .pclk, .presetn, .cpu_reset_n, .external_fetch_select, .step_req_n, .ale,
   .program_store_strobe_n, .first_test_pin_o, .first_test_pin_oe_n, .bus_o,
   .bus_oe_n, .port2_oe_n);

//--- sim/step_ctl_model.sv
`timescale 1ns/1ns
module step_ctl_model #(
   parameter int POR  = 60,
   parameter int HOLD = 75
) (
   // clock and strobe from the device
   input wire logic pclk,
   input wire logic ale,
   // bench commands
   input wire logic run,
   input wire logic step,
   input wire logic rst_req,
   // driven pins
   output logic     step_req_n,
   output logic     cpu_reset_n
);
   int cnt = POR;
   initial step_req_n = 1'b1;
   // reset source: shorter power-up hold, longer holds on request
   always @(posedge pclk) begin
      if (rst_req) begin
         cnt <= HOLD;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
   assign cpu_reset_n = (cnt == 0);
   // step flip-flop: strobe low clears it, a step sets it while strobe high
   always @(posedge pclk) begin
      if (run || (step && ale)) begin
         step_req_n <= 1'b1;
      end else if (!ale) begin
         step_req_n <= 1'b0;
      end
   end
endmodule // step_ctl_model

//--- sim/mcu_timing_reset_single_step_test.sv
`timescale 1ns/1ns
module mcu_timing_reset_single_step_test;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, pc;
   logic        cpu_reset_n, external_fetch_select, step_req_n, timer_ovf_evt;
   logic [7:0]  opcode_in, bus_o, port1_o, port2_o, port2_oe_n;
   logic        ale, program_store_strobe_n, first_test_pin_o, run, step;
   logic        first_test_pin_oe_n, bus_oe_n, port1_oe_n, rst_req;
   int          error_cnt, num_checks;

   mcu_timing_reset_single_step #(.POR_HOLD_CYCLES(20)) DUT (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .cpu_reset_n, .external_fetch_select, .step_req_n,
      .opcode_in, .timer_ovf_evt, .ale, .program_store_strobe_n,
      .first_test_pin_o, .first_test_pin_oe_n, .bus_o, .bus_oe_n,
      .port1_o, .port1_oe_n, .port2_o, .port2_oe_n);
   step_ctl_model #(.POR(60), .HOLD(75)) u_ctl (
      .pclk, .ale, .run, .step, .rst_req, .step_req_n, .cpu_reset_n);

   // clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wait_lvl(ref logic s, input logic v);
      int n;
      for (n = 0; n < 300 && s !== v; n++) @(posedge pclk);
      if (s !== v) begin
         error_cnt++;
         complete_run();
      end
   endtask
   // one apb transfer; a fresh edge keeps setup apart from the last release
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
      if (pready !== 1'b1) begin
         error_cnt++;
         complete_run();
      end
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_halt;
      int n;
      q = 32'h0;
      for (n = 0; n < 30 && q[mcu_timing_pkg::STAT_HALT] !== 1'b1; n++)
         apb(1'b0, mcu_timing_pkg::STATUS_OFS, 32'h0);
      chk(q[mcu_timing_pkg::STAT_HALT], 1'b1);
   endtask
   // five machine cycles of processor reset
   task automatic rst_chk(input logic fs);
      external_fetch_select <= fs;
      @(posedge pclk);
      rst_req <= 1'b1;
      @(posedge pclk);
      rst_req <= 1'b0;
      repeat (40) @(posedge pclk);
      chk(bus_oe_n, !fs);
      chk(port1_oe_n, 1'b1);
      if (fs) wait_lvl(program_store_strobe_n, 1'b0);
      wait_lvl(cpu_reset_n, 1'b1);
      apb(1'b0, mcu_timing_pkg::CTRL_OFS, 32'h0);
      chk(q, 32'h0);
      chk(first_test_pin_oe_n, 1'b1);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      error_cnt = 0;
      num_checks = 0;
      {presetn, psel, penable, pwrite, timer_ovf_evt, step, rst_req} = 7'h00;
      {paddr, pwdata, opcode_in} = 52'h0;
      external_fetch_select = 1'b0;
      run = 1'b1;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      wait_lvl(cpu_reset_n, 1'b1);
      apb(1'b0, mcu_timing_pkg::STATUS_OFS, 32'h0);
      chk(q[mcu_timing_pkg::STAT_POROK], 1'b1);
      chk(first_test_pin_oe_n, 1'b1);
      // flags, banks, interrupt enables, timer run, clock command
      apb(1'b1, mcu_timing_pkg::CTRL_OFS, 32'h8000_007f);
      timer_ovf_evt <= 1'b1;
      @(posedge pclk);
      timer_ovf_evt <= 1'b0;
      apb(1'b0, mcu_timing_pkg::CTRL_OFS, 32'h0);
      chk(q, 32'h0000_01ff);
      chk(first_test_pin_oe_n, 1'b0);
      apb(1'b1, mcu_timing_pkg::PORTS_OFS, 32'h0003_a55a);
      repeat (2) @(posedge pclk);
      chk(port1_o, 8'h5a);
      apb(1'b0, 12'h010, 32'h0);
      chk(err, 1'b1);
      chk(q, 32'h0);
      rst_chk(1'b1);
      rst_chk(1'b0);
      // single step: one-cycle then two-cycle opcode
      run <= 1'b0;
      wait_halt;
      for (int i = 0; i < 2; i++) begin
         pc = q;
         chk(bus_o, pc[7:0]);
         chk(port2_o[3:0], pc[11:8]);
         chk(ale, 1'b1);
         opcode_in <= (i != 0) ? 8'h50 : 8'h00;
         step <= 1'b1;
         @(posedge pclk);
         step <= 1'b0;
         wait_lvl(ale, 1'b0);
         wait_halt;
         chk(q[11:0], pc[11:0] + 12'(i + 1));
      end
      run <= 1'b1;
      repeat (60) @(posedge pclk);
      apb(1'b0, mcu_timing_pkg::STATUS_OFS, 32'h0);
      chk(q[mcu_timing_pkg::STAT_HALT], 1'b0);
      complete_run();
   end
endmodule // mcu_timing_reset_single_step_test
